// *** pkg/dsw_pkg.sv ***
// Shared constants and carriers for the drive status word one block.
// Assumes a single 40 MHz clock and indications produced on that clock.
package dsw_pkg;

  // Word geometry
  localparam int unsigned WORD_W = 16;

  // Bit positions within the status word
  localparam int unsigned BIT_RDY_ON = 0;
  localparam int unsigned BIT_RDY_OPER = 1;
  localparam int unsigned BIT_RUN = 2;
  localparam int unsigned BIT_FAULT = 3;
  localparam int unsigned BIT_NO_COAST_STOP = 4;
  localparam int unsigned BIT_NO_QUICK_STOP = 5;
  localparam int unsigned BIT_ON_INHIBIT = 6;
  localparam int unsigned BIT_WARNING = 7;
  localparam int unsigned BIT_NO_DEVIATION = 8;
  localparam int unsigned BIT_PD_CONTROL = 9;
  localparam int unsigned BIT_COMP_REACHED = 10;
  localparam int unsigned BIT_UNDERVOLT = 11;
  localparam int unsigned BIT_MAIN_CONTACTOR = 12;
  localparam int unsigned BIT_RAMP_ACTIVE = 13;
  localparam int unsigned BIT_SETP_POSITIVE = 14;
  localparam int unsigned BIT_LINE_DIP_BUF = 15;

  // Reset values: only the process data control bit is set in the word, and only it is clear in the complement
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0200;
  localparam logic [WORD_W-1:0] COMP_RESET = 16'hfdff;

  // Raw indications from sequence control, messages, faults, ramp, buffering
  typedef struct packed {
    logic line_dip_buffering;
    logic setpoint_positive;
    logic ramp_active;
    logic main_contactor_req;
    logic undervoltage_fault;
    logic compare_reached;
    logic deviation;
    logic warning;
    logic switch_on_inhibit;
    logic quick_stop_active;
    logic coast_stop_active;
    logic fault_active;
    logic running;
    logic ready_for_operation;
    logic ready_to_switch_on;
  } dsw_ind_t;

  // Read answer on the process data channel
  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } dsw_pd_rsp_t;

  // Whole state of the top module
  typedef struct packed {
    logic [WORD_W-1:0] word;
    dsw_pd_rsp_t rsp;
  } dsw_state_t;

endpackage : dsw_pkg

// *** rtl/dsw_pair_reg.sv ***
// Registered true/complement pair for each bit of a status word.
// Assumes the word input is already on the same clock domain.
`timescale 1ns/10ps
module dsw_pair_reg #(
  parameter int unsigned WIDTH = dsw_pkg::WORD_W,
  parameter logic [WIDTH-1:0] TRUE_RESET = dsw_pkg::WORD_RESET
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Next word value
  input wire logic [WIDTH-1:0] word_i,
  // Pair outputs
  output logic [WIDTH-1:0] true_o,
  output logic [WIDTH-1:0] comp_o
);

  typedef struct packed {
    logic [WIDTH-1:0] t;
    logic [WIDTH-1:0] c;
  } dsw_pair_state_t;

  dsw_pair_state_t state_reg;
  dsw_pair_state_t state_next;

  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < int'(WIDTH); i++) begin
      state_next.t[i] = word_i[i];
      state_next.c[i] = ~word_i[i];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_reg.t <= TRUE_RESET;
      state_reg.c <= ~TRUE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Each output bit is a single flop, handy for routing to other functions
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    assign true_o[g] = state_reg.t[g];
    assign comp_o[g] = state_reg.c[g];
  end

endmodule : dsw_pair_reg

// *** rtl/dsw_status_word.sv ***
// Drive status word one: gathers drive indications into a 16-bit word.
// Assumes all indications come from logic on ref_clk_i, so no synchroniser.
//
// Functional notes
// - Bit 0 is 1 when ready to switch on, else 0.
// - Bit 1 is 1 when DC link charged, pulses blocked, else 0.
// - Bit 2 is 1 while running with output voltage, 0 when blocked.
// - Bit 3 is 1 while a fault is active, 0 without fault.
// - Bit 6 is 1 while switch-on inhibit is in force.
// - Bit 8 is 1 when no setpoint/actual deviation is detected.
// - Bit 9 is always 1: process data control requested.
// - Bit 10 is 1 when the comparison value is reached.
// - Bit 11 is 1 while an undervoltage fault is present.
// - Bit 12 is 1 while main contactor energize is requested.
// - Bit 13 is 1 while the setpoint ramp generator is ramping.
// - Bit 14 is 1 for positive setpoint, 0 for negative.
// - Bit 15 is 1 while line dip buffering is active.
`timescale 1ns/10ps
module dsw_status_word (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Indications from the drive functions
  input wire dsw_pkg::dsw_ind_t ind_i,
  // Process data channel read request
  input wire logic pd_rd_i,
  // Status word as seen on the connector and the local operator panel
  output logic [dsw_pkg::WORD_W-1:0] drive_status_word_one_o,
  // Process data channel answer
  output dsw_pkg::dsw_pd_rsp_t pd_rsp_o,
  // Binary pairs for routing
  output logic [dsw_pkg::WORD_W-1:0] bit_true_o,
  output logic [dsw_pkg::WORD_W-1:0] bit_comp_o
);

  dsw_pkg::dsw_state_t state_reg;
  dsw_pkg::dsw_state_t state_next;

  // Sequence control group
  function automatic logic [dsw_pkg::WORD_W-1:0] seq_bits(
    input dsw_pkg::dsw_ind_t ind
  );
    logic [dsw_pkg::WORD_W-1:0] w;
    w = '0;
    w[dsw_pkg::BIT_RDY_ON] = ind.ready_to_switch_on;
    w[dsw_pkg::BIT_RDY_OPER] = ind.ready_for_operation;
    w[dsw_pkg::BIT_RUN] = ind.running;
    w[dsw_pkg::BIT_FAULT] = ind.fault_active;
    // Stop bits read 1 when the stop is not active
    w[dsw_pkg::BIT_NO_COAST_STOP] = ~ind.coast_stop_active;
    w[dsw_pkg::BIT_NO_QUICK_STOP] = ~ind.quick_stop_active;
    w[dsw_pkg::BIT_ON_INHIBIT] = ind.switch_on_inhibit;
    // Held high; the controller always owns the drive
    w[dsw_pkg::BIT_PD_CONTROL] = 1'b1;
    w[dsw_pkg::BIT_MAIN_CONTACTOR] = ind.main_contactor_req;
    return w;
  endfunction : seq_bits

  // Alarm and fault processing group
  function automatic logic [dsw_pkg::WORD_W-1:0] alarm_bits(
    input dsw_pkg::dsw_ind_t ind
  );
    logic [dsw_pkg::WORD_W-1:0] w;
    w = '0;
    w[dsw_pkg::BIT_WARNING] = ind.warning;
    w[dsw_pkg::BIT_UNDERVOLT] = ind.undervoltage_fault;
    return w;
  endfunction : alarm_bits

  // Message group; deviation inverted so 1 means on track
  function automatic logic [dsw_pkg::WORD_W-1:0] msg_bits(
    input dsw_pkg::dsw_ind_t ind
  );
    logic [dsw_pkg::WORD_W-1:0] w;
    w = '0;
    w[dsw_pkg::BIT_NO_DEVIATION] = ~ind.deviation;
    w[dsw_pkg::BIT_COMP_REACHED] = ind.compare_reached;
    w[dsw_pkg::BIT_SETP_POSITIVE] = ind.setpoint_positive;
    return w;
  endfunction : msg_bits

  // Setpoint ramp and line dip buffering group
  function automatic logic [dsw_pkg::WORD_W-1:0] ramp_buf_bits(
    input dsw_pkg::dsw_ind_t ind
  );
    logic [dsw_pkg::WORD_W-1:0] w;
    w = '0;
    w[dsw_pkg::BIT_RAMP_ACTIVE] = ind.ramp_active;
    w[dsw_pkg::BIT_LINE_DIP_BUF] = ind.line_dip_buffering;
    return w;
  endfunction : ramp_buf_bits

  // Groups own disjoint bits, so an OR merges them without overlap
  function automatic logic [dsw_pkg::WORD_W-1:0] pack_word(
    input dsw_pkg::dsw_ind_t ind
  );
    return seq_bits(ind) | alarm_bits(ind) | msg_bits(ind) |
      ramp_buf_bits(ind);
  endfunction : pack_word

  always_comb begin
    state_next = state_reg;
    // One cycle of latency keeps every output straight from a flop
    state_next.word = pack_word(ind_i);
    state_next.rsp.valid = pd_rd_i;
    // A read answers with the word taken at the same edge as the request
    if (pd_rd_i) begin
      state_next.rsp.data = pack_word(ind_i);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_reg.word <= dsw_pkg::WORD_RESET;
      state_reg.rsp.valid <= 1'b0;
      state_reg.rsp.data <= dsw_pkg::WORD_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign drive_status_word_one_o = state_reg.word;
  assign pd_rsp_o = state_reg.rsp;

  // Pairs track the word edge for edge since both take the next value
  dsw_pair_reg #(
    .WIDTH(dsw_pkg::WORD_W),
    .TRUE_RESET(dsw_pkg::WORD_RESET)
  ) u_pair (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .word_i(state_next.word),
    .true_o(bit_true_o),
    .comp_o(bit_comp_o)
  );

endmodule : dsw_status_word

// *** tb/dsw_props.sv ***
// Checker on the status word ports.
// Assumes one clock; bound to the top module below.
`timescale 1ns/10ps
module dsw_props (
  // Watched ports
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire dsw_pkg::dsw_ind_t ind_i,
  input wire logic pd_rd_i,
  input wire logic [15:0] drive_status_word_one_o,
  input wire dsw_pkg::dsw_pd_rsp_t pd_rsp_o,
  input wire logic [15:0] bit_true_o,
  input wire logic [15:0] bit_comp_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  wire [15:0] w = drive_status_word_one_o;
  wire [14:0] p = ind_i;
  rdy_bits_a: assert property (!$past(srst_i) |->
    w[1:0] == $past(p[1:0])) else $error("ready bits wrong");
  run_fault_a: assert property (!$past(srst_i) |->
    w[3:2] == $past(p[3:2])) else $error("run or fault bit wrong");
  on_inhibit_a: assert property (!$past(srst_i) |->
    w[6] == $past(p[6])) else $error("inhibit bit wrong");
  no_dev_a: assert property (!$past(srst_i) |->
    w[8] != $past(p[8])) else $error("deviation bit wrong");
  pd_ctrl_a: assert property (w[9] && !bit_comp_o[9])
    else $error("control bit not set");
  cmp_uv_a: assert property (!$past(srst_i) |->
    w[11:10] == $past(p[10:9])) else $error("compare bits wrong");
  mc_ramp_a: assert property (!$past(srst_i) |->
    w[13:12] == $past(p[12:11])) else $error("contactor bits wrong");
  sign_buf_a: assert property (!$past(srst_i) |->
    w[15:14] == $past(p[14:13])) else $error("sign bits wrong");
  bit_pair_a: assert property (bit_true_o == w && bit_comp_o == ~w)
    else $error("binary pair wrong");
  read_ans_a: assert property (pd_rd_i |=> pd_rsp_o.valid
    && pd_rsp_o.data == w) else $error("read answer wrong");
  rsp_idle_a: assert property (!pd_rd_i |=> !pd_rsp_o.valid)
    else $error("answer without read");
  rsp_hold_a: assert property (!pd_rd_i && !srst_i |=>
    $stable(pd_rsp_o.data)) else $error("answer data moved");
  cover property (pd_rd_i ##1 pd_rd_i);
  cover property (pd_rsp_o.valid);
  cover property ($rose(w[15]));
  cover property ($fell(w[8]));
endmodule : dsw_props
bind dsw_status_word dsw_props i_props (.ref_clk_i, .srst_i, .ind_i,
  .pd_rd_i, .drive_status_word_one_o, .pd_rsp_o, .bit_true_o, .bit_comp_o);

// *** tb/dsw_pd_reader.sv ***
// Controller side reading the word over the process data channel.
// Assumes answers arrive one cycle after each read pulse.
`timescale 1ns/10ps
module dsw_pd_reader (
  // Clock, reset, request from bench
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic req_i,
  // Channel
  input wire dsw_pkg::dsw_pd_rsp_t rsp_i,
  output logic pd_rd_o,
  output logic [15:0] data_o
);
  always_ff @(posedge ref_clk_i) begin
    pd_rd_o <= req_i && !srst_i;
    if (rsp_i.valid) begin
      data_o <= rsp_i.data;
    end
  end
endmodule : dsw_pd_reader

// *** tb/tb_drive_status_word_one.sv ***
// Self-checking bench for the status word block.
// Assumes checker and reader are compiled first.
`timescale 1ns/10ps
module tb_drive_status_word_one;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req = 1'b0;
  logic pd_rd;
  dsw_pkg::dsw_ind_t ind = '0;
  dsw_pkg::dsw_pd_rsp_t rsp;
  logic [15:0] word, btrue, bcomp, rd_data;
  int error_cnt = 0;
  int checked = 0;
  logic [30:0] rows [16] = '{{15'h0000, 16'h0330}, {15'h0001, 16'h0331},
    {15'h0002, 16'h0332}, {15'h0004, 16'h0334}, {15'h0008, 16'h0338},
    {15'h0040, 16'h0370}, {15'h0080, 16'h03b0}, {15'h0100, 16'h0230},
    {15'h0200, 16'h0730}, {15'h0400, 16'h0b30}, {15'h0800, 16'h1330},
    {15'h1000, 16'h2330}, {15'h2000, 16'h4330}, {15'h4000, 16'h8330},
    {15'h0030, 16'h0300}, {15'h7fff, 16'hfecf}};
  always #12.5 clk = ~clk;
  dsw_status_word i_dut (.ref_clk_i(clk), .srst_i(srst), .ind_i(ind),
    .pd_rd_i(pd_rd), .drive_status_word_one_o(word), .pd_rsp_o(rsp),
    .bit_true_o(btrue), .bit_comp_o(bcomp));
  dsw_pd_reader i_rd (.ref_clk_i(clk), .srst_i(srst), .req_i(req),
    .rsp_i(rsp), .pd_rd_o(pd_rd), .data_o(rd_data));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1 chk(word, 16'h0200);
    chk(bcomp, 16'hfdff);
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk);
      ind <= rows[i][30:16];
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      #1 chk(word, rows[i][15:0]);
      chk(btrue, rows[i][15:0]);
      chk(bcomp, ~rows[i][15:0]);
      repeat (2) @(posedge clk);
      #1 chk(rd_data, rows[i][15:0]);
    end
    $display("test rows done");
    // Back to back reads while the word moves under them
    @(posedge clk);
    ind <= 15'h2000;
    req <= 1'b1;
    @(posedge clk);
    ind <= 15'h0001;
    @(posedge clk);
    ind <= 15'h4000;
    req <= 1'b0;
    @(posedge clk);
    ind <= 15'h7fff;
    #1 chk(rd_data, 16'h0331);
    chk(rsp.data, 16'h8330);
    chk(16'(rsp.valid), 16'h0001);
    @(posedge clk);
    #1 chk(rd_data, 16'h8330);
    chk(16'(rsp.valid), 16'h0000);
    $display("test back to back done");
    // Reset in mid-run with every indication high
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1 chk(word, 16'h0200);
    chk(bcomp, 16'hfdff);
    @(posedge clk);
    #1 chk(word, 16'hfecf);
    $display("test mid reset done");
    complete_run();
  end
  initial begin
    repeat (400) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule : tb_drive_status_word_one
